// File: logic/pulse_wiper_position_control.sv
// wiper position controller: debounce, lockout, stepping and nonvolatile store
//
// Operation
// - wiper position has 64 settings, both end terminals included
// - up request moves toward high end, down request toward low end
// - direction inputs active low; falling edge starts measuring low time
// - low pulse over 1 ms up to half a second steps once
// - pulse after too short a high gap is ignored, no step
// - hold beyond half second: step then, then every 100 ms
// - saturate at ends; opposite move only after first input released
// - contact bounce filtered inside, bare pushbuttons suffice
// - direction inputs ignored at least 10 ms after power-up
// - store input sampled at power-up: low selects command store mode
// - automatic mode stores the position when supply is removed
// - command mode: rising store pulse of 1 us stores the position
// - store input activity overrides both direction inputs
// - stepping pauses during a store and resumes if still active
// - command store lasts at least 4 ms from the store rise
// - pulses within 500 ms of each other form one train
// - internal thresholds may deviate up to ten percent
`timescale 1ns/1ps
module pulse_wiper_position_control
    import wiper_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic step_up_request_n,
    input wire logic step_down_request_n,
    input wire logic nv_save_control,
    input wire logic supply_fail,
    input wire logic [`POS_BITS-1:0] nv_read_data,
    output logic [`POS_BITS-1:0] wiper_pos,
    output logic nv_wr_en,
    output logic [`POS_BITS-1:0] nv_wr_data,
    output logic store_busy,
    output logic cmd_store_mode,
    output logic ready,
    output logic up_train,
    output logic down_train
);

    localparam logic [`CNT_BITS-1:0] LOCK_LAST = `CNT_BITS'(`LOCKOUT_TICKS - 1);
    localparam logic [`CNT_BITS-1:0] STORE_LAST = `CNT_BITS'(`STORE_TICKS - 1);
    localparam logic [`DEB_BITS-1:0] DEB_LAST = `DEB_BITS'(`DEBOUNCE_TICKS - 1);
    localparam int UP = 0;
    localparam int DOWN = 1;

    wiper_top_s s_r;
    wiper_top_s s_nxt;

    logic tick;
    logic [1:0] raw_active;
    logic [1:0] step;
    logic [1:0] train;
    logic dec_enable;
    logic dec_pause;

    // nominal figures; the tolerance band is absorbed by exact counts
    wiper_time_base #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_time_base (
        .clk(clk),
        .rstn(rstn),
        .tick(tick)
    );

    assign raw_active = {~step_down_request_n, ~step_up_request_n};
    assign dec_enable = s_r.unlocked;
    assign dec_pause = s_r.store_busy;

    generate
        for (genvar i = 0; i < 2; i++) begin : g_dir
            wiper_dir_decoder u_dec (
                .clk(clk),
                .rstn(rstn),
                .tick(tick),
                .req_active(s_r.deb_lvl[i]),
                .enable(dec_enable),
                .pause(dec_pause),
                .step(step[i]),
                .train(train[i])
            );
        end
    endgenerate

    // next position for one step, held at the end terminals
    function automatic logic [`POS_BITS-1:0] step_pos(
        input logic [`POS_BITS-1:0] pos,
        input logic go_up
    );
        logic [`POS_BITS-1:0] res;
        res = pos;
        if (go_up) begin
            if (pos != `POS_MAX) begin
                res = pos + `POS_BITS'h1;
            end
        end else begin
            if (pos != `POS_MIN) begin
                res = pos - `POS_BITS'h1;
            end
        end
        return res;
    endfunction : step_pos

    always_comb begin
        s_nxt = s_r;
        s_nxt.nv_wr_en = 1'b0;
        s_nxt.str_prev = nv_save_control;
        s_nxt.fail_prev = supply_fail;

        // contact bounce filter: level changes only after a stable spell
        for (int i = 0; i < 2; i++) begin
            if (raw_active[i] == s_r.deb_lvl[i]) begin
                s_nxt.deb_cnt[i] = '0;
            end else if (tick) begin
                if (s_r.deb_cnt[i] >= DEB_LAST) begin
                    s_nxt.deb_lvl[i] = raw_active[i];
                    s_nxt.deb_cnt[i] = '0;
                end else begin
                    s_nxt.deb_cnt[i] = s_r.deb_cnt[i] + `DEB_BITS'h1;
                end
            end
        end

        if (!s_r.loaded) begin
            // first cycle after reset release: strap and stored position
            s_nxt.loaded = 1'b1;
            s_nxt.cmd_mode = ~nv_save_control;
            s_nxt.pos = nv_read_data;
        end else begin
            // power-up lockout of the direction inputs
            if (!s_r.unlocked && tick) begin
                if (s_r.lock_cnt >= LOCK_LAST) begin
                    s_nxt.unlocked = 1'b1;
                end else begin
                    s_nxt.lock_cnt = s_r.lock_cnt + `CNT_BITS'h1;
                end
            end

            // stepping; each direction accepted only while the other is released
            if (step[UP] && !s_r.deb_lvl[DOWN]) begin
                s_nxt.pos = step_pos(s_r.pos, 1'b1);
            end else if (step[DOWN] && !s_r.deb_lvl[UP]) begin
                s_nxt.pos = step_pos(s_r.pos, 1'b0);
            end

            // store request and busy window
            if (s_r.store_busy) begin
                if (tick) begin
                    if (s_r.store_cnt >= STORE_LAST) begin
                        s_nxt.store_busy = 1'b0;
                    end else begin
                        s_nxt.store_cnt = s_r.store_cnt + `CNT_BITS'h1;
                    end
                end
            end else if ((s_r.cmd_mode && nv_save_control && !s_r.str_prev)
                         || (!s_r.cmd_mode && supply_fail && !s_r.fail_prev)) begin
                s_nxt.store_busy = 1'b1;
                s_nxt.store_cnt = '0;
                s_nxt.nv_wr_en = 1'b1;
                s_nxt.nv_wr_data = s_r.pos;
            end
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wiper_pos = s_r.pos;
    assign nv_wr_en = s_r.nv_wr_en;
    assign nv_wr_data = s_r.nv_wr_data;
    assign store_busy = s_r.store_busy;
    assign cmd_store_mode = s_r.cmd_mode;
    assign ready = s_r.unlocked;
    assign up_train = train[UP];
    assign down_train = train[DOWN];

endmodule : pulse_wiper_position_control

// File: logic/wiper_cfg.svh
// timing, width and position range constants for the wiper position controller
`ifndef WIPER_CFG_SVH
`define WIPER_CFG_SVH

`define CLK_PERIOD_NS 4
`define TICK_NS 10000
`define TICK_CYCLES ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MS_NS 1000000
`define US_NS 1000

`define T_PULSE_MIN_MS 1
`define T_HOLD_MS 500
`define T_REPEAT_MS 100
`define T_HIGH_MIN_MS 1
`define T_TRAIN_MS 500
`define T_LOCKOUT_MS 10
`define T_STORE_MS 4
`define T_DEBOUNCE_US 200

`define TICKS_UP_MS(ms) (((ms) * `MS_NS + `TICK_NS - 1) / `TICK_NS)
`define TICKS_DN_MS(ms) (((ms) * `MS_NS) / `TICK_NS)

`define PULSE_MIN_TICKS `TICKS_UP_MS(`T_PULSE_MIN_MS)
`define HOLD_TICKS `TICKS_DN_MS(`T_HOLD_MS)
`define REPEAT_TICKS `TICKS_DN_MS(`T_REPEAT_MS)
`define HIGH_MIN_TICKS `TICKS_UP_MS(`T_HIGH_MIN_MS)
`define TRAIN_TICKS `TICKS_DN_MS(`T_TRAIN_MS)
`define LOCKOUT_TICKS `TICKS_UP_MS(`T_LOCKOUT_MS)
`define STORE_TICKS `TICKS_UP_MS(`T_STORE_MS)
`define DEBOUNCE_TICKS ((`T_DEBOUNCE_US * `US_NS + `TICK_NS - 1) / `TICK_NS)

`define POS_BITS 6
`define POS_STEPS 64
`define POS_MIN 6'h00
`define POS_MAX 6'h3f
`define CNT_BITS 16
`define DEB_BITS 8

`endif

// File: logic/wiper_dir_decoder.sv
// pulse-width decoder for one direction input
`timescale 1ns/1ps
module wiper_dir_decoder
    import wiper_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic tick,
    input wire logic req_active,
    input wire logic enable,
    input wire logic pause,
    output logic step,
    output logic train
);

    localparam logic [`CNT_BITS-1:0] PULSE_MIN = `CNT_BITS'(`PULSE_MIN_TICKS);
    localparam logic [`CNT_BITS-1:0] HOLD_LAST = `CNT_BITS'(`HOLD_TICKS - 1);
    localparam logic [`CNT_BITS-1:0] REPEAT_LAST = `CNT_BITS'(`REPEAT_TICKS - 1);
    localparam logic [`CNT_BITS-1:0] HIGH_MIN = `CNT_BITS'(`HIGH_MIN_TICKS);
    localparam logic [`CNT_BITS-1:0] TRAIN_MAX = `CNT_BITS'(`TRAIN_TICKS);

    dir_dec_s s_r;
    dir_dec_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.step = 1'b0;
        if (!enable) begin
            // a pulse already low when the lockout ends is not a fresh edge
            s_nxt.st = req_active ? DIR_IGNORE : DIR_IDLE;
            s_nxt.low_cnt = '0;
            s_nxt.high_cnt = '0;
            s_nxt.gap_ok = 1'b1;
            s_nxt.in_train = 1'b0;
        end else if (tick && !pause) begin
            unique case (s_r.st)
                DIR_IDLE: begin
                    if (req_active) begin
                        s_nxt.low_cnt = '0;
                        s_nxt.st = s_r.gap_ok ? DIR_LOW : DIR_IGNORE;
                    end else begin
                        if (s_r.high_cnt < TRAIN_MAX) begin
                            s_nxt.high_cnt = s_r.high_cnt + `CNT_BITS'h1;
                        end else begin
                            s_nxt.in_train = 1'b0;
                        end
                        if (s_r.high_cnt + `CNT_BITS'h1 >= HIGH_MIN) begin
                            s_nxt.gap_ok = 1'b1;
                        end
                    end
                end
                DIR_LOW: begin
                    if (req_active) begin
                        if (s_r.low_cnt >= HOLD_LAST) begin
                            s_nxt.step = 1'b1;
                            s_nxt.low_cnt = '0;
                            s_nxt.st = DIR_REPEAT;
                        end else begin
                            s_nxt.low_cnt = s_r.low_cnt + `CNT_BITS'h1;
                        end
                    end else begin
                        if (s_r.low_cnt > PULSE_MIN) begin
                            s_nxt.step = 1'b1;
                            s_nxt.in_train = 1'b1;
                        end
                        s_nxt.st = DIR_IDLE;
                        s_nxt.high_cnt = '0;
                        s_nxt.gap_ok = 1'b0;
                    end
                end
                DIR_REPEAT: begin
                    if (req_active) begin
                        if (s_r.low_cnt >= REPEAT_LAST) begin
                            s_nxt.step = 1'b1;
                            s_nxt.low_cnt = '0;
                        end else begin
                            s_nxt.low_cnt = s_r.low_cnt + `CNT_BITS'h1;
                        end
                    end else begin
                        s_nxt.st = DIR_IDLE;
                        s_nxt.high_cnt = '0;
                        s_nxt.gap_ok = 1'b0;
                    end
                end
                DIR_IGNORE: begin
                    if (!req_active) begin
                        s_nxt.st = DIR_IDLE;
                        s_nxt.high_cnt = '0;
                        s_nxt.gap_ok = 1'b0;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '{st: DIR_IDLE, low_cnt: '0, high_cnt: '0, gap_ok: 1'b1,
                     in_train: 1'b0, step: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    assign step = s_r.step;
    assign train = s_r.in_train;

endmodule : wiper_dir_decoder

// File: logic/wiper_pkg.sv
// types shared by the wiper position controller modules
`include "wiper_cfg.svh"
package wiper_pkg;

    typedef enum logic [1:0] {
        DIR_IDLE,
        DIR_LOW,
        DIR_REPEAT,
        DIR_IGNORE
    } dir_state_e;

    typedef struct packed {
        logic [`CNT_BITS-1:0] div;
        logic tick;
    } time_base_s;

    typedef struct packed {
        dir_state_e st;
        logic [`CNT_BITS-1:0] low_cnt;
        logic [`CNT_BITS-1:0] high_cnt;
        logic gap_ok;
        logic in_train;
        logic step;
    } dir_dec_s;

    typedef struct packed {
        logic loaded;
        logic cmd_mode;
        logic unlocked;
        logic [`CNT_BITS-1:0] lock_cnt;
        logic [1:0] deb_lvl;
        logic [1:0][`DEB_BITS-1:0] deb_cnt;
        logic str_prev;
        logic fail_prev;
        logic store_busy;
        logic [`CNT_BITS-1:0] store_cnt;
        logic nv_wr_en;
        logic [`POS_BITS-1:0] nv_wr_data;
        logic [`POS_BITS-1:0] pos;
    } wiper_top_s;

endpackage : wiper_pkg

// File: logic/wiper_time_base.sv
// free-running internal time base, one tick per tick period
`timescale 1ns/1ps
module wiper_time_base
    import wiper_pkg::*;
#(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rstn,
    output logic tick
);

    localparam logic [`CNT_BITS-1:0] DIV_LAST = `CNT_BITS'(TICK_CYCLES - 1);

    time_base_s s_r;
    time_base_s s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.tick = 1'b0;
        if (s_r.div >= DIV_LAST) begin
            s_nxt.div = '0;
            s_nxt.tick = 1'b1;
        end else begin
            s_nxt.div = s_r.div + `CNT_BITS'h1;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick = s_r.tick;

endmodule : wiper_time_base

// File: test/button_partner.sv
// pushbutton or processor model for the control inputs
`timescale 1ns/1ps
module button_partner (
    input wire logic clk,
    output logic up_n,
    output logic down_n,
    output logic str
);
    initial begin
        up_n = 1'b1;
        down_n = 1'b1;
        str = 1'b0;
    end

    task automatic press(input logic up, input int low, input int gap, input bit bounce);
        for (int i = 0; i < (bounce ? 5 : 1); i++) begin
            @(negedge clk);
            if (up) up_n = i[0]; else down_n = i[0];
            if (bounce) repeat (2) @(negedge clk);
        end
        repeat (low) @(negedge clk);
        up_n = 1'b1;
        down_n = 1'b1;
        repeat (gap) @(negedge clk);
    endtask : press

    task automatic store_pulse();
        @(negedge clk);
        str = 1'b1;
        repeat (250) @(negedge clk);
        str = 1'b0;
    endtask : store_pulse

    task automatic set_str(input logic v);
        str = v;
    endtask : set_str
endmodule : button_partner

// File: test/tb.sv
// self-checking bench for the wiper position controller
`timescale 1ns/1ps
module tb;
    localparam int TC = 1;
    logic clk, rstn, up_n, down_n, str, supply_fail;
    logic [5:0] nv_read_data, wiper_pos, nv_wr_data, wr_last;
    logic nv_wr_en, store_busy, cmd_store_mode, ready, up_train, down_train;
    int mismatches = 0;
    int num_checks = 0;
    int wr_cnt = 0;

    button_partner u_partner (.clk(clk), .up_n(up_n), .down_n(down_n), .str(str));
    pulse_wiper_position_control #(.TICK_CYCLES(TC)) u_dut (
        .clk(clk), .rstn(rstn), .step_up_request_n(up_n), .step_down_request_n(down_n),
        .nv_save_control(str), .supply_fail(supply_fail), .nv_read_data(nv_read_data),
        .wiper_pos(wiper_pos), .nv_wr_en(nv_wr_en), .nv_wr_data(nv_wr_data),
        .store_busy(store_busy), .cmd_store_mode(cmd_store_mode), .ready(ready),
        .up_train(up_train), .down_train(down_train)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    always @(negedge clk) begin
        if (nv_wr_en === 1'b1) begin
            wr_cnt++;
            wr_last = nv_wr_data;
        end
    end

    task automatic chk(input logic [5:0] got, input logic [5:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            $display("FAIL t=%0t %s", $time, msg);
            mismatches++;
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    task automatic do_reset(input logic [5:0] nv, input logic s);
        rstn = 1'b0;
        nv_read_data = nv;
        u_partner.set_str(s);
        repeat (8) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        chk(wiper_pos, nv, "load");
        chk({5'h0, cmd_store_mode}, {5'h0, ~s}, "mode");
    endtask : do_reset

    task automatic wait_ready();
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
        chk({5'h0, ready}, 6'h01, "ready");
    endtask : wait_ready

    task automatic t_lockout();
        u_partner.press(1'b1, 300, 150, 1'b0);
        chk(wiper_pos, 6'h3e, "lockout step");
        wait_ready();
        $display("test lockout done");
    endtask : t_lockout

    task automatic t_single();
        u_partner.press(1'b1, 300, 150, 1'b1);
        chk(wiper_pos, 6'h3f, "up step");
        chk({5'h0, up_train}, 6'h01, "up train");
        u_partner.press(1'b1, 300, 150, 1'b0);
        chk(wiper_pos, 6'h3f, "top end");
        u_partner.press(1'b0, 300, 150, 1'b1);
        chk(wiper_pos, 6'h3e, "down step");
        chk({5'h0, down_train}, 6'h01, "down train");
        u_partner.press(1'b0, 50, 150, 1'b0);
        chk(wiper_pos, 6'h3e, "short pulse");
        u_partner.press(1'b0, 300, 30, 1'b0);
        u_partner.press(1'b0, 300, 150, 1'b0);
        chk(wiper_pos, 6'h3d, "short gap");
        $display("test single done");
    endtask : t_single

    task automatic t_store();
        logic [5:0] held;
        wr_cnt = 0;
        fork
            u_partner.press(1'b1, 700, 150, 1'b0);
            begin
                repeat (100) @(negedge clk);
                u_partner.store_pulse();
            end
            begin
                repeat (150) @(negedge clk);
                held = wiper_pos;
                repeat (300) @(negedge clk);
                chk(wiper_pos, held, "frozen");
                chk({5'h0, store_busy}, 6'h01, "busy");
            end
        join
        chk(wiper_pos, 6'h3e, "resumed");
        chk(wr_last, 6'h3d, "stored");
        supply_fail = 1'b1;
        repeat (10) @(negedge clk);
        supply_fail = 1'b0;
        chk(wr_cnt[5:0], 6'h01, "one write");
        $display("test store done");
    endtask : t_store

    task automatic t_hold();
        fork
            u_partner.press(1'b0, 65000, 150, 1'b0);
            begin
                repeat (49500) @(negedge clk);
                chk(wiper_pos, 6'h3e, "before hold");
                repeat (1000) @(negedge clk);
                chk(wiper_pos, 6'h3d, "hold step");
                repeat (9000) @(negedge clk);
                chk(wiper_pos, 6'h3d, "before repeat");
                repeat (1000) @(negedge clk);
                chk(wiper_pos, 6'h3c, "repeat step");
            end
        join
        chk(wiper_pos, 6'h3c, "hold release");
        chk({5'h0, up_train}, 6'h00, "train over");
        $display("test hold done");
    endtask : t_hold

    task automatic t_auto();
        do_reset(6'h00, 1'b1);
        wait_ready();
        u_partner.press(1'b0, 300, 150, 1'b0);
        chk(wiper_pos, 6'h00, "low end");
        u_partner.press(1'b1, 300, 150, 1'b0);
        chk(wiper_pos, 6'h01, "up from end");
        wr_cnt = 0;
        supply_fail = 1'b1;
        repeat (10) @(negedge clk);
        chk(wr_last, 6'h01, "auto store");
        chk(wr_cnt[5:0], 6'h01, "auto count");
        supply_fail = 1'b0;
        $display("test auto done");
    endtask : t_auto

    initial begin
        rstn = 1'b0;
        supply_fail = 1'b0;
        nv_read_data = 6'h3e;
        do_reset(6'h3e, 1'b0);
        t_lockout();
        t_single();
        t_store();
        t_hold();
        t_auto();
        finish_test();
    end

    initial begin
        repeat (90000) @(posedge clk);
        mismatches++;
        $display("FAIL t=%0t watchdog", $time);
        finish_test();
    end
endmodule : tb

// File: test/wiper_properties.sv
// port assertions for the wiper position controller
`timescale 1ns/1ps
`include "wiper_cfg.svh"
module wiper_properties #(
    parameter int TICK_CYCLES = 1
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic nv_save_control,
    input wire logic supply_fail,
    input wire logic [`POS_BITS-1:0] nv_read_data,
    input wire logic [`POS_BITS-1:0] wiper_pos,
    input wire logic nv_wr_en,
    input wire logic [`POS_BITS-1:0] nv_wr_data,
    input wire logic store_busy,
    input wire logic cmd_store_mode,
    input wire logic ready
);
    logic [31:0] up_r;
    logic [31:0] busy_r;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            up_r <= '0;
            busy_r <= '0;
        end else begin
            up_r <= up_r + 32'h1;
            busy_r <= store_busy ? busy_r + 32'h1 : '0;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    load_value_a: assert property ((rstn && !$past(rstn)) |=>
        wiper_pos == $past(nv_read_data) && cmd_store_mode == !$past(nv_save_control))
        else $error("bad load at reset release");
    mode_hold_a: assert property (($past(rstn) && $past(rstn, 2)) |-> $stable(cmd_store_mode))
        else $error("store mode changed");
    lock_quiet_a: assert property ((!ready && $past(rstn) && $past(rstn, 2)) |->
        $stable(wiper_pos))
        else $error("wiper moved in lockout");
    lock_len_a: assert property ($rose(ready) |->
        up_r >= 1000 * TICK_CYCLES && up_r <= 1100 * TICK_CYCLES + 4)
        else $error("lockout length wrong");
    one_step_a: assert property ((ready && $past(ready) && wiper_pos != $past(wiper_pos)) |->
        ({1'b0, wiper_pos} == {1'b0, $past(wiper_pos)} + 7'h01 ||
         {1'b0, wiper_pos} + 7'h01 == {1'b0, $past(wiper_pos)}))
        else $error("wiper jump or wrap");
    store_freeze_a: assert property ((store_busy && $past(store_busy, 2)) |-> $stable(wiper_pos))
        else $error("wiper moved during store");
    write_pulse_a: assert property (nv_wr_en |->
        (store_busy && nv_wr_data == $past(wiper_pos)) ##1 !nv_wr_en)
        else $error("bad nonvolatile write");
    cmd_store_a: assert property ((cmd_store_mode && $past(rstn) && !store_busy &&
        $rose(nv_save_control)) |=> nv_wr_en && store_busy)
        else $error("command store not started");
    auto_store_a: assert property ((!cmd_store_mode && $past(rstn) && !store_busy &&
        $rose(supply_fail)) |=> nv_wr_en && store_busy)
        else $error("auto store not started");
    store_len_a: assert property ($fell(store_busy) |->
        busy_r >= 400 * TICK_CYCLES - 1 && busy_r <= 440 * TICK_CYCLES + 4)
        else $error("store window length wrong");
endmodule : wiper_properties

bind pulse_wiper_position_control wiper_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .clk(clk), .rstn(rstn), .nv_save_control(nv_save_control), .supply_fail(supply_fail),
    .nv_read_data(nv_read_data), .wiper_pos(wiper_pos), .nv_wr_en(nv_wr_en),
    .nv_wr_data(nv_wr_data), .store_busy(store_busy), .cmd_store_mode(cmd_store_mode),
    .ready(ready)
);
